// file: arce_pkg.sv
// Constants and types shared by the read command engine
package arce_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_FEAT = 4'h1;
  localparam logic [3:0] IDX_CNT  = 4'h2;
  localparam logic [3:0] IDX_SEC  = 4'h3;
  localparam logic [3:0] IDX_CYLL = 4'h4;
  localparam logic [3:0] IDX_CYLH = 4'h5;
  localparam logic [3:0] IDX_HEAD = 4'h6;
  localparam logic [3:0] IDX_CMD  = 4'h7;
  localparam logic [3:0] IDX_MULT = 4'h8;

  // Opcodes and feature code
  localparam logic [7:0] OP_RBUF   = 8'hE4;
  localparam logic [7:0] OP_RMULT  = 8'hC4;
  localparam logic [7:0] OP_RLONG0 = 8'h22;
  localparam logic [7:0] OP_RLONG1 = 8'h23;
  localparam logic [7:0] OP_RSEC0  = 8'h20;
  localparam logic [7:0] OP_RSEC1  = 8'h21;
  localparam logic [7:0] OP_RVER0  = 8'h40;
  localparam logic [7:0] OP_RVER1  = 8'h41;
  localparam logic [7:0] FEAT_LONG4 = 8'hBB;

  // Transfer sizes
  localparam int SEC_WORDS  = 256;
  localparam int LONG_EXTRA = 4;
  localparam logic [8:0] MAX_SECS = 9'h100;

  // Status, error and head register bit positions
  localparam int ST_BSY  = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DRQ  = 3;
  localparam int ST_CORR = 2;
  localparam int ST_ERR  = 0;
  localparam int ER_UNC  = 6;
  localparam int ER_ABRT = 2;
  localparam int HEAD_LBA = 6;

  // Media result codes
  localparam logic [1:0] MERR_NONE = 2'h0;
  localparam logic [1:0] MERR_CORR = 2'h1;
  localparam logic [1:0] MERR_UNC  = 2'h2;

  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_XFER} arce_state_e;
  typedef enum logic [2:0] {K_BUF, K_SEC, K_LONG, K_MULT, K_VER} arce_kind_e;

endpackage : arce_pkg

// file: arce_read_engine.sv
// Read command engine: task-file registers on APB, sector buffer, media port
//
// Overview of operation
// - Opcode E4H returns current sector buffer, normal read handshake.
// - Opcode C4H interrupts once per block, not per sector.
// - Block read counts sectors; full blocks then remainder block.
// - Block read with block mode off or unset aborts.
// - Media error in a block is posted at block start; block still sent.
// - Block read interrupts when DRQ rises for each block.
// - Sector and block reads move 1 to 256 sectors; zero means 256.
// - Transfer starts at address in sector, cylinder and head registers.
// - On success address registers hold the last sector read.
// - On error stop at failing sector, load its address, keep data.
// - Block read continues only after correctable errors.
// - Long read returns 512 bytes as words then 4 single bytes.
// - Opcodes 22H and 23H skip correction check; no data error flagged.
// - Long read always moves one sector only.
// - Sector read: set BSY, fill, set DRQ, clear BSY, interrupt.
// - Verify sets BSY, never DRQ, sends no data.
// - Verify done: clear BSY, interrupt, address at last verified.
// - Verify error: load failing address; count keeps sectors left.
// - LBA bits 27-24 head, 23-16 cyl high, 15-8 cyl low, 7-0 sector.
// - Block count of zero disables block reads.
// - Long reads carry four extra bytes by default.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps

module arce_read_engine #(
  parameter int         MAX_BLK  = 4,
  parameter logic [7:0] SPT      = 8'h20,
  parameter logic [3:0] HEAD_MAX = 4'hF
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             ataIrq,
  output logic             mediaReq,
  output logic [27:0]      mediaAddr,
  output logic             mediaLba,
  output logic             mediaNoEcc,
  output logic             mediaVerify,
  input  wire logic        mediaWe,
  input  wire logic [8:0]  mediaWOff,
  input  wire logic [15:0] mediaWData,
  input  wire logic        mediaDone,
  input  wire logic [1:0]  mediaErr
);

  localparam int BUF_WORDS = MAX_BLK * arce_pkg::SEC_WORDS + 2;
  localparam int PW = $clog2(BUF_WORDS + arce_pkg::LONG_EXTRA);
  localparam logic [7:0] MAXB8 = 8'(MAX_BLK);

  typedef struct packed {
    arce_pkg::arce_state_e st;
    arce_pkg::arce_kind_e  kind;
    logic                  ack;
    logic [31:0]           rdata;
    logic [7:0]            feat;
    logic [7:0]            cnt;
    logic [7:0]            secn;
    logic [7:0]            cylL;
    logic [7:0]            cylH;
    logic [7:0]            head;
    logic [7:0]            mult;
    logic                  abrt;
    logic                  unc;
    logic                  corr;
    logic                  irq;
    logic                  errSeen;
    logic                  fatal;
    logic                  lba;
    logic                  mreq;
    logic [8:0]            left;
    logic [8:0]            blk;
    logic [8:0]            fidx;
    logic [PW-1:0]         ptr;
    logic [27:0]           cur;
    logic [27:0]           errA;
  } arce_regs_s;

  arce_regs_s q;
  arce_regs_s n;
  logic [15:0] mem [BUF_WORDS];

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Next sector in LBA or CHS order
  function automatic logic [27:0] nextAddr(input logic [27:0] a,
                                           input logic        lba);
    logic [27:0] r;
    r = a;
    if (lba) begin
      r = a + 28'h1;
    end else if (a[7:0] != SPT) begin
      r[7:0] = a[7:0] + 8'h01;
    end else begin
      r[7:0] = 8'h01;
      if (a[27:24] != HEAD_MAX) begin
        r[27:24] = a[27:24] + 4'h1;
      end else begin
        r[27:24] = 4'h0;
        r[23:8]  = a[23:8] + 16'h1;
      end
    end
    return r;
  endfunction : nextAddr

  function automatic logic [8:0] secCount(input logic [7:0] c);
    return (c == 8'h00) ? arce_pkg::MAX_SECS : {1'b0, c};
  endfunction : secCount

  // Sectors in the next block
  function automatic logic [8:0] blkLen(input logic [8:0] l,
                                        input logic [7:0] m);
    return (l < {1'b0, m}) ? l : {1'b0, m};
  endfunction : blkLen

  ////////////////////////////////////////////////////////////////////////////
  // Decode and read mux

  logic [3:0]    idx;
  logic          hit;
  logic          acc;
  logic          done;
  logic          multOn;
  logic          lastRd;
  logic          bad;
  logic          cor;
  logic [PW-1:0] lastPtr;
  logic [PW-1:0] rIdx;
  logic [PW-1:0] ext;
  logic [15:0]   word;
  logic [7:0]    status;
  logic [31:0]   rdVal;

  assign idx  = paddr[5:2];
  assign hit  = (paddr[7:6] == 2'h0) && (idx <= arce_pkg::IDX_MULT);
  assign acc  = psel & penable;
  assign done = acc & q.ack;
  assign multOn = (q.mult != 8'h00) && (q.mult <= MAXB8);

  // DRQ stays up across the whole block, so one check covers it
  assign lastPtr = (q.kind == arce_pkg::K_LONG) ?
    PW'(arce_pkg::SEC_WORDS + arce_pkg::LONG_EXTRA - 1) :
    PW'(q.blk * arce_pkg::SEC_WORDS - 1);
  assign lastRd = done & ~pwrite & (idx == arce_pkg::IDX_DATA) &
                  (q.st == arce_pkg::S_XFER) & (q.ptr == lastPtr);

  // Long read tail: bytes from the two words after the sector
  assign ext  = q.ptr - PW'(arce_pkg::SEC_WORDS);
  assign rIdx = (q.kind == arce_pkg::K_LONG &&
                 q.ptr >= PW'(arce_pkg::SEC_WORDS)) ?
                PW'(arce_pkg::SEC_WORDS) + (ext >> 1) : q.ptr;
  always_comb begin
    word = mem[rIdx];
    if (q.kind == arce_pkg::K_LONG &&
        q.ptr >= PW'(arce_pkg::SEC_WORDS)) begin
      word = {8'h00, ext[0] ? mem[rIdx][15:8] : mem[rIdx][7:0]};
    end
  end

  always_comb begin
    status = 8'h00;
    status[arce_pkg::ST_BSY]  = (q.st == arce_pkg::S_FETCH);
    status[arce_pkg::ST_DRDY] = (q.st != arce_pkg::S_FETCH);
    status[arce_pkg::ST_DRQ]  = (q.st == arce_pkg::S_XFER);
    status[arce_pkg::ST_CORR] = q.corr;
    status[arce_pkg::ST_ERR]  = q.abrt | q.unc;
  end

  always_comb begin
    rdVal = 32'h0000_0000;
    unique case (idx)
      arce_pkg::IDX_DATA:
        rdVal[15:0] = (q.st == arce_pkg::S_XFER) ? word : 16'h0000;
      arce_pkg::IDX_FEAT: begin
        rdVal[arce_pkg::ER_UNC]  = q.unc;
        rdVal[arce_pkg::ER_ABRT] = q.abrt;
      end
      arce_pkg::IDX_CNT:  rdVal[7:0] = q.cnt;
      arce_pkg::IDX_SEC:  rdVal[7:0] = q.secn;
      arce_pkg::IDX_CYLL: rdVal[7:0] = q.cylL;
      arce_pkg::IDX_CYLH: rdVal[7:0] = q.cylH;
      arce_pkg::IDX_HEAD: rdVal[7:0] = q.head;
      arce_pkg::IDX_CMD:  rdVal[7:0] = status;
      arce_pkg::IDX_MULT: rdVal[7:0] = q.mult;
      default:            rdVal = 32'h0000_0000;
    endcase
  end

  // Long read never reports data errors from the media
  assign bad = (mediaErr == arce_pkg::MERR_UNC) &
               (q.kind != arce_pkg::K_LONG);
  assign cor = (mediaErr == arce_pkg::MERR_CORR) &
               (q.kind != arce_pkg::K_LONG);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = q;
    n.mreq = 1'b0;
    n.ack  = acc & ~q.ack;
    if (acc & ~q.ack) begin
      n.rdata = hit ? rdVal : 32'h0000_0000;
    end

    // Read side effects at the completing edge
    if (done & ~pwrite) begin
      if (idx == arce_pkg::IDX_CMD) begin
        n.irq = 1'b0;
      end
      if (idx == arce_pkg::IDX_DATA && q.st == arce_pkg::S_XFER) begin
        n.ptr = q.ptr + PW'(1);
      end
    end

    // Writes only while idle, so the address stays coherent
    if (done & pwrite & hit & (q.st == arce_pkg::S_IDLE)) begin
      unique case (idx)
        arce_pkg::IDX_FEAT: n.feat = pwdata[7:0];
        arce_pkg::IDX_CNT:  n.cnt  = pwdata[7:0];
        arce_pkg::IDX_SEC:  n.secn = pwdata[7:0];
        arce_pkg::IDX_CYLL: n.cylL = pwdata[7:0];
        arce_pkg::IDX_CYLH: n.cylH = pwdata[7:0];
        arce_pkg::IDX_HEAD: n.head = pwdata[7:0];
        // Zero or an unsupported count leaves block mode off
        arce_pkg::IDX_MULT: n.mult = (pwdata[7:0] <= MAXB8) ?
                                     pwdata[7:0] : 8'h00;
        arce_pkg::IDX_CMD: begin
          n.abrt    = 1'b0;
          n.unc     = 1'b0;
          n.corr    = 1'b0;
          n.irq     = 1'b0;
          n.errSeen = 1'b0;
          n.fatal   = 1'b0;
          n.fidx    = 9'h000;
          n.ptr     = '0;
          n.blk     = 9'h001;
          n.lba     = q.head[arce_pkg::HEAD_LBA];
          n.cur     = {q.head[3:0], q.cylH, q.cylL, q.secn};
          n.left    = secCount(q.cnt);
          n.st      = arce_pkg::S_FETCH;
          n.mreq    = 1'b1;
          unique case (pwdata[7:0])
            arce_pkg::OP_RBUF: begin
              n.kind = arce_pkg::K_BUF;
              n.left = 9'h001;
              n.st   = arce_pkg::S_XFER;
              n.mreq = 1'b0;
              n.irq  = 1'b1;
            end
            arce_pkg::OP_RSEC0, arce_pkg::OP_RSEC1:
              n.kind = arce_pkg::K_SEC;
            arce_pkg::OP_RLONG0, arce_pkg::OP_RLONG1: begin
              n.kind = arce_pkg::K_LONG;
              n.left = 9'h001;
            end
            arce_pkg::OP_RVER0, arce_pkg::OP_RVER1:
              n.kind = arce_pkg::K_VER;
            arce_pkg::OP_RMULT: begin
              n.kind = arce_pkg::K_MULT;
              n.blk  = blkLen(secCount(q.cnt), q.mult);
              if (!multOn) begin
                n.abrt = 1'b1;
                n.irq  = 1'b1;
                n.st   = arce_pkg::S_IDLE;
                n.mreq = 1'b0;
              end
            end
            default: begin
              n.abrt = 1'b1;
              n.irq  = 1'b1;
              n.st   = arce_pkg::S_IDLE;
              n.mreq = 1'b0;
            end
          endcase
        end
        default: n.feat = q.feat;
      endcase
    end

    // Media result for one sector
    if (q.st == arce_pkg::S_FETCH && mediaDone) begin
      if ((bad | cor) & ~q.errSeen) begin
        n.errSeen = 1'b1;
        n.errA    = q.cur;
      end
      n.unc   = q.unc | bad;
      n.corr  = q.corr | cor;
      n.fatal = q.fatal | bad;
      if (q.kind == arce_pkg::K_VER) begin
        if (bad || q.left == 9'h001) begin
          {n.head[3:0], n.cylH, n.cylL, n.secn} = q.cur;
          n.irq = 1'b1;
          n.st  = arce_pkg::S_IDLE;
          if (bad) begin
            n.cnt = q.left[7:0];
          end
        end else begin
          n.left = q.left - 9'h001;
          n.cur  = nextAddr(q.cur, q.lba);
          n.mreq = 1'b1;
        end
      end else if (q.fidx + 9'h001 < q.blk) begin
        n.fidx = q.fidx + 9'h001;
        n.cur  = nextAddr(q.cur, q.lba);
        n.mreq = 1'b1;
      end else begin
        // Block ready: error and address posted as DRQ rises
        {n.head[3:0], n.cylH, n.cylL, n.secn} =
          n.errSeen ? n.errA : q.cur;
        n.st  = arce_pkg::S_XFER;
        n.ptr = '0;
        n.irq = 1'b1;
      end
    end

    // End of a block of host reads
    if (lastRd) begin
      n.ptr  = '0;
      n.left = q.left - q.blk;
      if (n.left == 9'h000 || q.fatal ||
          q.kind == arce_pkg::K_BUF) begin
        n.st = arce_pkg::S_IDLE;
      end else begin
        n.blk  = (q.kind == arce_pkg::K_MULT) ?
                 blkLen(n.left, q.mult) : 9'h001;
        n.fidx    = 9'h000;
        n.errSeen = 1'b0;
        n.cur     = nextAddr(q.cur, q.lba);
        n.st      = arce_pkg::S_FETCH;
        n.mreq    = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and buffer

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Buffer is not reset; stale contents are what read buffer returns
  always_ff @(posedge clk) begin
    if (mediaWe && q.st == arce_pkg::S_FETCH) begin
      mem[PW'(q.fidx * arce_pkg::SEC_WORDS + mediaWOff)] <= mediaWData;
    end
  end

  assign prdata      = q.rdata;
  assign pready      = q.ack;
  assign pslverr     = q.ack & ~hit;
  assign ataIrq      = q.irq;
  assign mediaReq    = q.mreq;
  assign mediaAddr   = q.cur;
  assign mediaLba    = q.lba;
  assign mediaNoEcc  = (q.kind == arce_pkg::K_LONG);
  assign mediaVerify = (q.kind == arce_pkg::K_VER);

endmodule : arce_read_engine

// file: arce_read_engine_monitor.sv
// Checker for the engine's bus and media request ports
`timescale 1ns/1ps
module arce_read_engine_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mediaReq,
  input wire logic        mediaNoEcc,
  input wire logic        mediaVerify
);
  logic acc;
  logic stRd;
  logic cmdWr;
  assign acc   = psel && penable && pready;
  assign stRd  = acc && !pwrite && paddr[5:2] == 4'h7;
  assign cmdWr = acc && pwrite && paddr[5:2] == 4'h7;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////
  ready_pulse_a:
    assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  wait_state_a:
    assert property ((psel && !penable) ##1 (psel && penable) |->
      !pready ##1 pready) else $error("wait state count wrong");
  err_map_a:
    assert property (acc |-> pslverr == (paddr[5:2] > 4'h8 ||
      paddr[7:6] != 2'h0)) else $error("pslverr against address wrong");
  req_pulse_a:
    assert property (mediaReq |=> !mediaReq)
    else $error("media request held");
  sector_start_a:
    assert property (cmdWr && pwdata[7:1] == 7'h10 |=>
      mediaReq && !mediaVerify) else $error("sector read did not fetch");
  verify_start_a:
    assert property (cmdWr && pwdata[7:1] == 7'h20 |=>
      mediaReq && mediaVerify) else $error("verify did not start");
  verify_nodrq_a:
    assert property (stRd && mediaVerify |-> !prdata[arce_pkg::ST_DRQ])
    else $error("data request during verify");
  long_start_a:
    assert property (cmdWr && pwdata[7:1] == 7'h11 |=>
      mediaReq && mediaNoEcc) else $error("long read check not skipped");
  long_noerr_a:
    assert property (stRd && mediaNoEcc |-> !prdata[arce_pkg::ST_ERR])
    else $error("error flagged on long read");
  cover property (acc && pslverr);
  cover property (mediaReq && mediaVerify);
  cover property (mediaReq && mediaNoEcc);
endmodule : arce_read_engine_monitor

// file: arce_media_model.sv
// Media side model: fills the sector buffer and reports fetch results
`timescale 1ns/1ps
module arce_media_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic [27:0] errAddr,
  input  wire logic [1:0]  errCode,
  input  wire logic        mediaReq,
  input  wire logic [27:0] mediaAddr,
  input  wire logic        mediaNoEcc,
  input  wire logic        mediaVerify,
  output logic             mediaWe,
  output logic [8:0]       mediaWOff,
  output logic [15:0]      mediaWData,
  output logic             mediaDone,
  output logic [1:0]       mediaErr
);
  logic        busy;
  logic        tick;
  logic [9:0]  cnt;
  logic [27:0] addr;
  // Idle lines toggle so a stale value never passes for data
  always @(posedge clk) begin
    mediaWe <= 1'h0;
    mediaDone <= 1'h0;
    mediaErr <= ~mediaErr;
    mediaWData <= ~mediaWData;
    tick <= ~tick;
    if (rst) begin
      busy <= 1'h0;
      tick <= 1'h0;
      mediaErr <= 2'h0;
      mediaWData <= 16'h0;
      mediaWOff <= 9'h0;
    end else if (mediaReq) begin
      busy <= 1'h1;
      cnt <= 10'h0;
      addr <= mediaAddr;
    end else if (busy && (!slow || tick)) begin
      // Long fetch adds two words of filler behind the sector
      if (!mediaVerify && cnt < (mediaNoEcc ? 10'h102 : 10'h100)) begin
        mediaWe <= 1'h1;
        mediaWOff <= cnt[8:0];
        mediaWData <= {addr[7:0], cnt[7:0]};
        cnt <= cnt + 10'h1;
      end else begin
        mediaDone <= 1'h1;
        busy <= 1'h0;
        mediaErr <= (addr == errAddr) ? errCode : 2'h0;
      end
    end
  end
endmodule : arce_media_model

// file: test_arce_read_engine.sv
// Self-checking bench for the read command engine
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch %0t got %0h exp %0h", $time, a, b); end end
module test_arce_read_engine;
  logic        clk = 1'h0, rst = 1'h1, slow = 1'h0, psel = 1'h0;
  logic        penable = 1'h0, pwrite = 1'h0, lastErr, gotReq = 1'h0;
  logic        pready, pslverr, ataIrq, mediaReq, mediaLba, mediaNoEcc;
  logic        mediaVerify, mediaWe, mediaDone, irqPrev = 1'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [27:0] mediaAddr, firstAddr, errAddr = 28'hFFFFFFF;
  logic [1:0]  errCode = 2'h0, mediaErr;
  logic [8:0]  mediaWOff;
  logic [15:0] mediaWData;
  logic [3:0]  headHi = 4'hE;
  int          error_cnt = 0, compares = 0, cyc = 0, irqCnt = 0, irq0;
  arce_read_engine arce_read_engine_inst (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ataIrq(ataIrq), .mediaReq(mediaReq), .mediaAddr(mediaAddr),
    .mediaLba(mediaLba), .mediaNoEcc(mediaNoEcc), .mediaVerify(mediaVerify),
    .mediaWe(mediaWe), .mediaWOff(mediaWOff), .mediaWData(mediaWData),
    .mediaDone(mediaDone), .mediaErr(mediaErr));
  arce_media_model arce_media_model_inst (.clk(clk), .rst(rst), .slow(slow),
    .errAddr(errAddr), .errCode(errCode), .mediaReq(mediaReq),
    .mediaAddr(mediaAddr), .mediaNoEcc(mediaNoEcc),
    .mediaVerify(mediaVerify), .mediaWe(mediaWe), .mediaWOff(mediaWOff),
    .mediaWData(mediaWData), .mediaDone(mediaDone), .mediaErr(mediaErr));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    irqPrev <= ataIrq;
    if (ataIrq === 1'h1 && irqPrev === 1'h0) irqCnt++;
    if (mediaReq === 1'h1 && !gotReq) begin
      firstAddr <= mediaAddr;
      gotReq <= 1'h1;
    end
    if (cyc == 90000) begin
      error_cnt++;
      stop_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [3:0] i, input logic [7:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic cmd(input logic [7:0] op, input logic [7:0] n,
                     input logic [27:0] a);
    apb(1'h1, 4'h2, n);
    apb(1'h1, 4'h3, a[7:0]);
    apb(1'h1, 4'h4, a[15:8]);
    apb(1'h1, 4'h5, a[23:16]);
    apb(1'h1, 4'h6, {headHi, a[27:24]});
    gotReq = 1'h0;
    apb(1'h1, 4'h7, op);
  endtask : cmd
  task automatic chkA(input logic [27:0] a);
    for (int k = 0; k < 4; k++) begin
      apb(1'h0, 4'(k + 3), 8'h0);
      `CHK(r[7:0] & (k == 3 ? 8'h0F : 8'hFF), 8'(a >> (8 * k)))
    end
  endtask : chkA
  // Host checks the request flag once per block, then reads blindly
  task automatic drain(input int secs, input logic [27:0] a0);
    for (int s = 0; s < secs; s++)
      for (int k = 0; k < arce_pkg::SEC_WORDS; k++) begin
        apb(1'h0, 4'h0, 8'h0);
        `CHK(r, {16'h0, 8'(a0 + s), 8'(k)})
      end
  endtask : drain
  task automatic waitIrq;
    int n;
    n = 0;
    while (ataIrq !== 1'h1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    `CHK(ataIrq, 1'h1)
    apb(1'h0, 4'h7, 8'h0);
  endtask : waitIrq
  task automatic stop_test;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    for (int i = 2; i < 9; i++) begin
      apb(1'h0, 4'(i), 8'h0);
      if (i != 7) `CHK(r, 32'h0)
    end
    apb(1'h0, 4'h9, 8'h0);
    `CHK({lastErr, r}, 33'h100000000)
    for (int i = 0; i < 2; i++) begin
      apb(1'h1, 4'h8, i ? 8'h05 : 8'h00);
      cmd(arce_pkg::OP_RMULT, 8'h04, 28'h10);
      waitIrq();
      `CHK(r[7:0] & 8'h89, 8'h01)
      apb(1'h0, 4'h1, 8'h0);
      `CHK(r, 32'h4)
    end
    slow <= 1'h1;
    for (int i = 0; i < 2; i++) begin
      cmd(i ? arce_pkg::OP_RSEC1 : arce_pkg::OP_RSEC0, 8'h02, 28'h1234500);
      for (int s = 0; s < 2; s++) begin
        waitIrq();
        `CHK(r[7:0] & 8'h88, 8'h08)
        drain(1, 28'h1234500 + s);
      end
      `CHK(firstAddr, 28'h1234500)
      `CHK(mediaLba, 1'h1)
      chkA(28'h1234501);
    end
    slow <= 1'h0;
    apb(1'h1, 4'h8, 8'h03);
    errAddr <= 28'h41;
    errCode <= arce_pkg::MERR_CORR;
    irq0 = irqCnt;
    cmd(arce_pkg::OP_RMULT, 8'h04, 28'h40);
    waitIrq();
    `CHK(r[7:0] & 8'h8D, 8'h0C)
    drain(3, 28'h40);
    waitIrq();
    drain(1, 28'h43);
    `CHK(irqCnt - irq0, 2)
    chkA(28'h43);
    apb(1'h1, 4'h8, 8'h02);
    errAddr <= 28'h51;
    errCode <= arce_pkg::MERR_UNC;
    cmd(arce_pkg::OP_RMULT, 8'h04, 28'h50);
    waitIrq();
    `CHK(r[7:0] & 8'h89, 8'h09)
    apb(1'h0, 4'h1, 8'h0);
    `CHK(r, 32'h40)
    chkA(28'h51);
    drain(2, 28'h50);
    apb(1'h0, 4'h7, 8'h0);
    `CHK(r[7:0] & 8'h88, 8'h00)
    cmd(arce_pkg::OP_RBUF, 8'h00, 28'h0);
    waitIrq();
    drain(1, 28'h50);
    apb(1'h1, 4'h1, arce_pkg::FEAT_LONG4);
    errAddr <= 28'h60;
    for (int i = 0; i < 2; i++) begin
      cmd(i ? arce_pkg::OP_RLONG1 : arce_pkg::OP_RLONG0, 8'h03, 28'h60);
      waitIrq();
      `CHK(r[7:0] & 8'h89, 8'h08)
      drain(1, 28'h60);
      for (int j = 0; j < arce_pkg::LONG_EXTRA; j++) begin
        apb(1'h0, 4'h0, 8'h0);
        `CHK(r, {24'h0, j[0] ? 8'h60 : 8'(j >> 1)})
      end
      apb(1'h0, 4'h7, 8'h0);
      `CHK(r[7:0] & 8'h88, 8'h00)
    end
    errAddr <= 28'hFFFFFFF;
    cmd(arce_pkg::OP_RVER0, 8'h00, 28'h100);
    waitIrq();
    `CHK(r[7:0] & 8'h89, 8'h00)
    chkA(28'h1FF);
    errAddr <= 28'h202;
    cmd(arce_pkg::OP_RVER1, 8'h05, 28'h200);
    waitIrq();
    `CHK(r[7:0] & 8'h89, 8'h01)
    chkA(28'h202);
    apb(1'h0, 4'h2, 8'h0);
    `CHK(r, 32'h3)
    // CHS walk: last sector of a track wraps to sector 1 of next head
    headHi = 4'hA;
    cmd(arce_pkg::OP_RVER0, 8'h02, 28'h20);
    waitIrq();
    `CHK(r[7:0] & 8'h89, 8'h00)
    `CHK(mediaLba, 1'h0)
    chkA(28'h1000001);
    stop_test();
  end
endmodule : test_arce_read_engine
bind arce_read_engine arce_read_engine_monitor arce_read_engine_monitor_inst (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mediaReq(mediaReq), .mediaNoEcc(mediaNoEcc),
  .mediaVerify(mediaVerify));
